// ### src/boot_pkg.sv
// Constants, state type and helpers for the serial EEPROM boot loader
// Notes on behaviour
// - Byte nine MSB selects autonomous or host boot
// - One I2C EEPROM, 128 bytes to 2KB
// - Host boot loads only timing and memory setup
// - Autonomous boot also sets aperture base addresses
// - Autonomous boot copies level 1 program to memory
// - Host boot reads only first 10 bytes
// - Autonomous program may fill almost 2 KB
// - Chip reset starts the boot sequence
// - After reset only boot, I2C, PCI run
// - Core and highway held in reset until released
// - Autonomous boot releases core and highway
// - Host boot releases highway only, core held
// - First byte read at boot clock over 1000
// - Later bytes at fastest rate byte zero allows
package boot_pkg;

  localparam logic [3:0]  DEV_TYPE        = 4'ha;
  localparam logic [2:0]  DEV_BLOCK       = 3'h0;
  localparam logic [7:0]  WORD_ADDR_START = 8'h00;
  localparam int          SLOW_DIV        = 1000;
  localparam int          SLOW_QTR        = SLOW_DIV / 4;
  localparam int          QTR_W           = 10;

  // Layout of byte zero
  localparam int          B0_LINES_BIT    = 7;
  localparam int          B0_APER_LSB     = 4;
  localparam int          B0_CLK_LSB      = 2;
  localparam int          B0_I2C_BIT      = 1;
  localparam int          B0_TEST_BIT     = 0;

  // Byte indices in the EEPROM image
  localparam int          MODE_BYTE       = 9;
  localparam int          MODE_BIT        = 7;
  localparam int          CFG_BYTES       = 10;
  localparam int          MEM_BASE_BYTE   = 10;
  localparam int          MMIO_BASE_BYTE  = 14;
  localparam int          LEN_BYTE        = 18;
  localparam int          HDR_BYTES       = 20;
  localparam int          CAP_SMALL       = 128;
  localparam int          CAP_LARGE       = 2048;

  // Boot clock and serial clock rates, kHz
  localparam int          BOOT_KHZ [4]    = '{100000, 75000, 50000, 33000};
  localparam int          I2C_STD_KHZ     = 100;
  localparam int          I2C_FAST_KHZ    = 400;

  localparam logic        CORE_RST_INIT   = 1'b1;
  localparam logic        HWY_RST_INIT    = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_TX, ST_RX, ST_HOLD, ST_STOP, ST_DRAIN, ST_DONE
  } boot_state_t;

  // Quarter of a serial clock period in boot clock cycles, rounded up
  function automatic logic [QTR_W-1:0] fast_qtr(input logic [1:0] clk_sel,
                                                input logic       fast);
    int f;
    int t;
    int q;
    f = BOOT_KHZ[clk_sel];
    t = fast ? I2C_FAST_KHZ : I2C_STD_KHZ;
    q = (f + 4 * t - 1) / (4 * t);
    return q[QTR_W-1:0];
  endfunction

endpackage

// ### src/serial_eeprom_boot_loader.sv
// Boot loader: I2C EEPROM reader, program FIFO and reset release
`timescale 1ns/10ps

module boot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t r_nxt;
  logic     push;
  logic     pop;

  assign in_ready_out  = (r.cnt != DEPTH[AW:0]);
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out  = r.mem[r.rp];

  always_comb begin
    r_nxt = r;
    push  = in_valid_in && in_ready_out;
    pop   = out_valid_out && out_ready_in;
    if (push) begin
      r_nxt.mem[r.wp] = in_data_in;
      r_nxt.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = r.rp + 1'b1;
    end
    if (push && !pop) begin
      r_nxt.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      r_nxt.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end
endmodule

module serial_eeprom_boot_loader
  import boot_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and chip reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // I2C pins, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // Program write port into main memory
  output logic             mem_wr_valid_out,
  input  wire logic        mem_wr_ready_in,
  output logic [31:0]      mem_wr_addr_out,
  output logic [7:0]       mem_wr_data_out,
  // Loaded configuration
  output logic [79:0]      boot_cfg_out,
  output logic [31:0]      mem_base_out,
  output logic [31:0]      mmio_base_out,
  output logic             autonomous_out,
  // Reset control and status
  output logic             core_rst_out,
  output logic             highway_rst_out,
  output logic             boot_done_out,
  output logic             boot_error_out
);

  typedef struct packed {
    boot_state_t             st;
    logic [QTR_W-1:0]        qtr;
    logic [QTR_W-1:0]        div;
    logic [1:0]              ph;
    logic [3:0]              bitn;
    logic [1:0]              txn;
    logic [7:0]              sh;
    logic [11:0]             idx;
    logic [11:0]             last_idx;
    logic [11:0]             cap_last;
    logic                    auto_mode;
    logic                    nack;
    logic                    ack_bad;
    logic                    retry;
    logic                    scl_lo;
    logic                    sda_lo;
    logic [1:0]              scl_s;
    logic [1:0]              sda_s;
    logic [HDR_BYTES-1:0][7:0] cfg;
    logic [31:0]             wr_addr;
    logic                    err;
    logic                    core_rst;
    logic                    hwy_rst;
    logic                    done;
  } boot_st_t;

  boot_st_t    r;
  boot_st_t    r_nxt;
  logic        tick;
  logic        stall;
  logic        push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [7:0]  b;
  logic [11:0] last;
  logic [11:0] cap;
  logic [11:0] len;

  function automatic logic [7:0] tx_byte(input logic [1:0] n);
    case (n)
      2'd0:    tx_byte = {DEV_TYPE, DEV_BLOCK, 1'b0};
      2'd1:    tx_byte = WORD_ADDR_START;
      default: tx_byte = {DEV_TYPE, DEV_BLOCK, 1'b1};
    endcase
  endfunction

  // Each bit spans four quarter periods; quarter length sets the rate
  always_comb begin
    r_nxt       = r;
    r_nxt.scl_s = {r.scl_s[0], scl_in};
    r_nxt.sda_s = {r.sda_s[0], sda_in};
    tick        = 1'b0;
    push        = 1'b0;
    b           = r.sh;
    last        = r.last_idx;
    cap         = r.cap_last;
    len         = 12'h000;
    // A slave holding the clock low stretches the current quarter
    stall       = !r.scl_lo && !r.scl_s[1];
    if (!stall) begin
      if (r.div == r.qtr - 1'b1) begin
        r_nxt.div = '0;
        tick      = 1'b1;
      end else begin
        r_nxt.div = r.div + 1'b1;
      end
    end
    if (tick) begin
      r_nxt.ph = r.ph + 2'd1;
    end

    case (r.st)
      ST_IDLE: begin
        r_nxt.qtr       = SLOW_QTR[QTR_W-1:0];
        r_nxt.div       = '0;
        r_nxt.ph        = 2'd0;
        r_nxt.txn       = 2'd0;
        r_nxt.idx       = 12'h000;
        r_nxt.last_idx  = MODE_BYTE[11:0];
        r_nxt.cap_last  = 12'(CAP_LARGE - 1);
        r_nxt.scl_lo    = 1'b0;
        r_nxt.sda_lo    = 1'b0;
        r_nxt.st        = ST_START;
      end
      ST_START: begin
        if (tick) begin
          case (r.ph)
            2'd0:    r_nxt.sda_lo = 1'b0;
            2'd1:    r_nxt.scl_lo = 1'b0;
            2'd2:    r_nxt.sda_lo = 1'b1;
            default: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.sh     = tx_byte(r.txn);
              r_nxt.bitn   = 4'd0;
              r_nxt.st     = ST_TX;
            end
          endcase
        end
      end
      ST_TX: begin
        if (tick) begin
          case (r.ph)
            2'd0:    r_nxt.sda_lo = (r.bitn == 4'd8) ? 1'b0 : !r.sh[7];
            2'd1:    r_nxt.scl_lo = 1'b0;
            2'd2:    r_nxt.ack_bad = r.sda_s[1];
            default: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.sh     = {r.sh[6:0], 1'b0};
              r_nxt.bitn   = r.bitn + 4'd1;
              if (r.bitn == 4'd8) begin
                r_nxt.bitn = 4'd0;
                if (r.ack_bad) begin
                  r_nxt.retry = 1'b1;
                  r_nxt.err   = 1'b1;
                  r_nxt.st    = ST_STOP;
                end else if (r.txn == 2'd0) begin
                  r_nxt.txn = 2'd1;
                  r_nxt.sh  = tx_byte(2'd1);
                end else if (r.txn == 2'd1) begin
                  r_nxt.txn = 2'd2;
                  r_nxt.st  = ST_START;
                end else begin
                  r_nxt.st  = ST_RX;
                end
              end
            end
          endcase
        end
      end
      ST_RX: begin
        if (tick) begin
          case (r.ph)
            2'd0:    r_nxt.sda_lo = (r.bitn == 4'd8) && !r.nack;
            2'd1:    r_nxt.scl_lo = 1'b0;
            2'd2: begin
              if (r.bitn != 4'd8) begin
                r_nxt.sh = {r.sh[6:0], r.sda_s[1]};
              end
            end
            default: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.bitn   = r.bitn + 4'd1;
              if (r.bitn == 4'd7) begin
                if (r.idx < 12'(HDR_BYTES)) begin
                  r_nxt.cfg[r.idx[4:0]] = b;
                end else begin
                  push = 1'b1;
                end
                if (r.idx == 12'h000) begin
                  r_nxt.qtr = fast_qtr(b[B0_CLK_LSB +: 2], b[B0_I2C_BIT]);
                  cap = b[B0_LINES_BIT] ? 12'(CAP_LARGE - 1)
                                        : 12'(CAP_SMALL - 1);
                end
                if (r.idx == 12'(MODE_BYTE)) begin
                  r_nxt.auto_mode = b[MODE_BIT];
                  if (b[MODE_BIT]) begin
                    last = 12'(LEN_BYTE + 1);
                  end
                end
                if (r.idx == 12'(MEM_BASE_BYTE + 3)) begin
                  r_nxt.wr_addr = {b, r.cfg[MEM_BASE_BYTE + 2],
                                   r.cfg[MEM_BASE_BYTE + 1], r.cfg[MEM_BASE_BYTE]};
                end
                if (r.idx == 12'(LEN_BYTE + 1)) begin
                  len  = {1'b0, b[2:0], r.cfg[LEN_BYTE]};
                  last = 12'(LEN_BYTE + 1) + len;
                end
                if (last > cap) begin
                  last = cap;
                end
                r_nxt.last_idx = last;
                r_nxt.cap_last = cap;
                r_nxt.nack     = (r.idx == last);
                r_nxt.idx      = r.idx + 12'd1;
              end
              if (r.bitn == 4'd8) begin
                r_nxt.bitn = 4'd0;
                if (r.nack) begin
                  r_nxt.st = ST_STOP;
                end else if (r.idx >= 12'(HDR_BYTES) && !fifo_in_ready) begin
                  // Memory slower than the EEPROM: hold the clock low
                  r_nxt.st = ST_HOLD;
                end
              end
            end
          endcase
        end
      end
      ST_HOLD: begin
        r_nxt.div = '0;
        r_nxt.ph  = 2'd0;
        if (fifo_in_ready) begin
          r_nxt.st = ST_RX;
        end
      end
      ST_STOP: begin
        if (tick) begin
          case (r.ph)
            2'd0:    r_nxt.sda_lo = 1'b1;
            2'd1:    r_nxt.scl_lo = 1'b0;
            2'd2:    r_nxt.sda_lo = 1'b0;
            default: begin
              r_nxt.retry = 1'b0;
              r_nxt.st    = r.retry ? ST_IDLE : ST_DRAIN;
            end
          endcase
        end
      end
      ST_DRAIN: begin
        // Releases wait until the whole program has reached memory
        if (!fifo_out_valid) begin
          r_nxt.hwy_rst = 1'b0;
          if (r.auto_mode) begin
            r_nxt.core_rst = 1'b0;
          end
          r_nxt.done = 1'b1;
          r_nxt.st   = ST_DONE;
        end
      end
      ST_DONE: begin
        r_nxt.div = '0;
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase

    if (fifo_out_valid && mem_wr_ready_in) begin
      r_nxt.wr_addr = r.wr_addr + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r          <= '0;
      r.st       <= ST_IDLE;
      r.qtr      <= SLOW_QTR[QTR_W-1:0];
      r.core_rst <= CORE_RST_INIT;
      r.hwy_rst  <= HWY_RST_INIT;
    end else begin
      r <= r_nxt;
    end
  end

  boot_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_data_in    (r.sh),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (mem_wr_ready_in)
  );

  // Open drain: only ever pull low
  assign scl_out          = 1'b0;
  assign sda_out          = 1'b0;
  assign scl_oe_n_out     = !r.scl_lo;
  assign sda_oe_n_out     = !r.sda_lo;
  assign mem_wr_valid_out = fifo_out_valid;
  assign mem_wr_data_out  = fifo_out_data;
  assign mem_wr_addr_out  = r.wr_addr;
  assign boot_cfg_out     = r.cfg[CFG_BYTES-1:0];
  assign mem_base_out     = {r.cfg[MEM_BASE_BYTE + 3], r.cfg[MEM_BASE_BYTE + 2],
                             r.cfg[MEM_BASE_BYTE + 1], r.cfg[MEM_BASE_BYTE]};
  assign mmio_base_out    = {r.cfg[MMIO_BASE_BYTE + 3], r.cfg[MMIO_BASE_BYTE + 2],
                             r.cfg[MMIO_BASE_BYTE + 1], r.cfg[MMIO_BASE_BYTE]};
  assign autonomous_out   = r.auto_mode;
  assign core_rst_out     = r.core_rst;
  assign highway_rst_out  = r.hwy_rst;
  assign boot_done_out    = r.done;
  assign boot_error_out   = r.err;

endmodule

// ### verification/boot_loader_assertions.sv
// Port checks for the boot loader
`timescale 1ns/10ps
module boot_loader_chk (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // Pins and write port
  input wire logic        scl_oe_n_out,
  input wire logic        sda_oe_n_out,
  input wire logic        mem_wr_valid_out,
  input wire logic        mem_wr_ready_in,
  input wire logic [31:0] mem_wr_addr_out,
  input wire logic [7:0]  mem_wr_data_out,
  // Results
  input wire logic [31:0] mem_base_out,
  input wire logic [31:0] mmio_base_out,
  input wire logic        autonomous_out,
  input wire logic        core_rst_out,
  input wire logic        highway_rst_out,
  input wire logic        boot_done_out,
  input wire logic        boot_error_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [9:0] cyc_r;
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in) cyc_r <= 10'h000;
    else if (cyc_r != 10'h3ff) cyc_r <= cyc_r + 10'h001;

  held_till_done_a: assert property (
    !boot_done_out |-> core_rst_out && highway_rst_out) else $error("freed early");
  done_sticky_a: assert property (
    boot_done_out |=> boot_done_out && !highway_rst_out) else $error("done dropped");
  release_empty_a: assert property (
    $rose(boot_done_out) |-> $fell(highway_rst_out) && !mem_wr_valid_out)
    else $error("released with data pending");
  auto_core_a: assert property (
    boot_done_out && autonomous_out |-> !core_rst_out) else $error("core held");
  host_core_a: assert property (
    boot_done_out && !autonomous_out |-> core_rst_out && !mem_wr_valid_out
    && mem_base_out == 32'h0 && mmio_base_out == 32'h0) else $error("host state");
  wr_hold_a: assert property (
    mem_wr_valid_out && !mem_wr_ready_in |=> mem_wr_valid_out
    && $stable(mem_wr_addr_out) && $stable(mem_wr_data_out)) else $error("write moved");
  wr_step_a: assert property (
    mem_wr_valid_out && mem_wr_ready_in |=> mem_wr_addr_out == $past(mem_wr_addr_out) + 32'h1)
    else $error("address step");
  error_sticky_a: assert property (
    boot_error_out |=> boot_error_out) else $error("error cleared");
  idle_pins_a: assert property (
    cyc_r < 10'h2e4 |-> scl_oe_n_out && sda_oe_n_out) else $error("early drive");
  start_cond_a: assert property (
    cyc_r == 10'h320 |-> !sda_oe_n_out && scl_oe_n_out) else $error("start shape");

  cover property (boot_done_out && autonomous_out);
  cover property (boot_done_out && !autonomous_out);
  cover property ((mem_wr_valid_out && !mem_wr_ready_in) [*8]);
  cover property ($rose(boot_error_out));
endmodule

bind serial_eeprom_boot_loader boot_loader_chk chk_u (.*);

// ### verification/eeprom_model.sv
// Behavioural I2C serial EEPROM facing the boot loader
`timescale 1ns/10ps
module eeprom_model (
  // Bus wires; SCL is only watched
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_pull_out,
  // Bench control and status
  input  wire logic   nack_once_in,
  output logic [11:0] rd_cnt_out,
  output logic [23:0] got_out
);
  logic [7:0]  mem [2048];
  logic [7:0]  sh_r;
  logic [10:0] ptr_r;
  logic        sel_r, rd_r, go_r, nacked_r;
  int          bits, nb;
  initial begin
    sda_pull_out = 1'b0;
    nacked_r = 1'b0;
    rd_cnt_out = 12'h000;
  end
  // Start or stop reframes and lets go of SDA
  always @(sda_in) begin
    if (scl_in === 1'b1) begin
      bits = 0;
      nb = 0;
      sel_r = 1'b0;
      rd_r = 1'b0;
      sda_pull_out = 1'b0;
    end
  end
  always @(posedge scl_in) begin
    if (bits < 8)
      sh_r = {sh_r[6:0], sda_in};
    else if (rd_r) begin
      go_r = go_r && !sda_in;
      rd_cnt_out = rd_cnt_out + 12'h001;
    end
    bits = bits + 1;
  end
  always @(negedge scl_in) begin
    if (bits == 8 && !rd_r) begin
      got_out = {got_out[15:0], sh_r};
      if (nb == 0) begin
        sel_r = sh_r[7:1] == 7'h50 && (nacked_r || !nack_once_in);
        nacked_r = 1'b1;
        // A fresh address write restarts the read count
        if (!sh_r[0])
          rd_cnt_out = 12'h000;
      end else if (sel_r)
        ptr_r = {3'h0, sh_r};
      sda_pull_out = sel_r;
    end else if (bits == 9) begin
      bits = 0;
      if (nb == 0 && sel_r && sh_r[0])
        {rd_r, go_r} = 2'b11;
      else if (rd_r)
        ptr_r = ptr_r + 11'h001;
      nb = nb + 1;
      sda_pull_out = rd_r && go_r && !mem[ptr_r][7];
    end else
      sda_pull_out = rd_r && go_r && bits < 8 && !mem[ptr_r][7 - bits];
  end
endmodule

// ### verification/serial_eeprom_boot_loader_tb_top.sv
// Bench: host boot with one refused address, then autonomous boot
`timescale 1ns/10ps
module serial_eeprom_boot_loader_tb_top;
  logic        sys_clk_in, rst_in, mem_wr_ready_in, nack_once, ee_pull;
  logic        scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, mem_wr_valid_out;
  logic        autonomous_out, core_rst_out, highway_rst_out, boot_done_out, boot_error_out;
  logic [31:0] mem_wr_addr_out, mem_base_out, mmio_base_out;
  logic [7:0]  mem_wr_data_out;
  logic [79:0] boot_cfg_out;
  logic [11:0] rd_cnt;
  logic [23:0] got;
  logic [31:0] wa_q [$];
  logic [7:0]  wd_q [$];
  int          fails, tests_run, cyc;
  time         t0, per;
  // Open-drain wires with pull-ups
  wire logic   scl_in = scl_oe_n_out | scl_out;
  wire logic   sda_in = (sda_oe_n_out | sda_out) & ~ee_pull;

  serial_eeprom_boot_loader #(.FIFO_DEPTH(16)) dut_u (.*);
  eeprom_model ee_u (.scl_in(scl_in), .sda_in(sda_in), .sda_pull_out(ee_pull),
    .nack_once_in(nack_once), .rd_cnt_out(rd_cnt), .got_out(got));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge scl_in) begin
    per = $time - t0;
    t0 = $time;
  end
  always @(posedge sys_clk_in) begin
    if (mem_wr_valid_out && mem_wr_ready_in) begin
      wa_q.push_back(mem_wr_addr_out);
      wd_q.push_back(mem_wr_data_out);
    end
  end
  always @(posedge sys_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 160000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic ok, input string msg);
    tests_run = tests_run + 1;
    if (ok !== 1'b1) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic load(input logic mode);
    for (int i = 0; i < 2048; i++)
      ee_u.mem[i] = 8'(i * 37 + 5);
    // Lines bit follows mode; 33 MHz code, fast grade: quarter of 21 cycles
    ee_u.mem[0] = {mode, 7'h0e};
    ee_u.mem[9][7] = mode;
    ee_u.mem[18] = 8'h11;
    ee_u.mem[19] = 8'h00;
    wa_q.delete();
    wd_q.delete();
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (12) @(negedge sys_clk_in);
    rst_in = 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 90000 && boot_done_out !== 1'b1; i++)
      @(negedge sys_clk_in);
    chk(boot_done_out === 1'b1, "no finish");
  endtask

  task automatic host_boot();
    logic [79:0] e;
    nack_once = 1'b1;
    load(1'b0);
    do_reset();
    repeat (2) @(posedge scl_in);
    @(negedge sys_clk_in);
    chk(per >= 4000 && per <= 4040, "slow clock");
    wait_done();
    for (int i = 0; i < 10; i++)
      e[8*i +: 8] = ee_u.mem[i];
    chk(boot_cfg_out === e && autonomous_out === 1'b0, "config");
    chk(core_rst_out === 1'b1 && highway_rst_out === 1'b0, "host release");
    chk(rd_cnt === 12'h00a && wa_q.size() == 0, "bytes read");
    chk(got === 24'ha0_00a1 && boot_error_out === 1'b1, "header");
    chk(scl_out === 1'b0 && sda_out === 1'b0, "open drain");
    chk(mem_base_out === 32'h0 && mmio_base_out === 32'h0, "bases");
    chk(per >= 336 && per <= 368, "fast clock");
    // In host boot core release belongs to the host driver, never to the loader
    repeat (100) @(negedge sys_clk_in);
    chk(core_rst_out === 1'b1, "core left to host");
  endtask

  task automatic auto_boot();
    logic [31:0] b;
    logic [11:0] n;
    nack_once = 1'b0;
    mem_wr_ready_in = 1'b0;
    load(1'b1);
    do_reset();
    for (int i = 0; i < 70000 && rd_cnt < 12'h024; i++)
      @(negedge sys_clk_in);
    repeat (1500) @(negedge sys_clk_in);
    n = rd_cnt;
    repeat (1500) @(negedge sys_clk_in);
    chk(rd_cnt === n && n >= 12'h024 && n <= 12'h025 && scl_in === 1'b0, "stall");
    chk(mem_wr_valid_out === 1'b1 && core_rst_out === 1'b1, "held");
    mem_wr_ready_in = 1'b1;
    wait_done();
    b = {ee_u.mem[13], ee_u.mem[12], ee_u.mem[11], ee_u.mem[10]};
    chk(wa_q.size() == 17, "write count");
    for (int i = 0; i < 17; i++)
      chk(wa_q[i] === b + i && wd_q[i] === ee_u.mem[20 + i], "program");
    chk(mem_base_out === b && autonomous_out === 1'b1, "memory base");
    b = {ee_u.mem[17], ee_u.mem[16], ee_u.mem[15], ee_u.mem[14]};
    chk(mmio_base_out === b, "mmio base");
    chk(core_rst_out === 1'b0 && highway_rst_out === 1'b0, "auto release");
    chk(boot_error_out === 1'b0 && rd_cnt === 12'h025, "reread");
  endtask

  initial begin
    rst_in = 1'b1;
    mem_wr_ready_in = 1'b0;
    nack_once = 1'b0;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    t0 = 0;
    host_boot();
    auto_boot();
    wrap_up();
  end
endmodule
